// [design/pms_clk_div.sv]
// divider that makes the reduced-rate enable pulses
`timescale 1ns/100ps
`default_nettype none
`include "pms_consts.svh"
module pms_clk_div #(
  parameter int DIV_CORE  = `PMS_DIV_CORE,
  parameter int DIV_FLASH = `PMS_DIV_FLASH
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // enables
  pms_div_if.provider div
);
  // refuse ratios the counters cannot serve
  if (DIV_CORE < 2 || DIV_CORE > 255 || DIV_FLASH < 2 || DIV_FLASH > 255) begin : g_chk
    $error("pms_clk_div: divider ratio out of range");
  end

  logic [7:0] core_cnt_r;
  logic [7:0] flash_cnt_r;
  logic       core_tick_r;
  logic       flash_tick_r;

  wire core_wrap  = (core_cnt_r == 8'(DIV_CORE - 1));
  wire flash_wrap = (flash_cnt_r == 8'(DIV_FLASH - 1));

  // free counters, held at zero while not needed
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_cnt_r   <= 8'h00;
      flash_cnt_r  <= 8'h00;
      core_tick_r  <= 1'b0;
      flash_tick_r <= 1'b0;
    end else begin
      core_cnt_r   <= (!div.run || core_wrap) ? 8'h00 : core_cnt_r + 8'h01;
      flash_cnt_r  <= (!div.run || flash_wrap) ? 8'h00 : flash_cnt_r + 8'h01;
      core_tick_r  <= div.run && core_wrap;
      flash_tick_r <= div.run && flash_wrap;
    end
  end

  assign div.core_tick  = core_tick_r;
  assign div.flash_tick = flash_tick_r;
endmodule // pms_clk_div
`default_nettype wire

// [design/pms_mode_seq.sv]
// chip power mode sequencer: mode state, clock gating, supplies, wake-up
`timescale 1ns/100ps
`default_nettype none
`include "pms_consts.svh"
// How it works
// - ten reduced-power modes besides normal run, held in one enum
// - wait and stop levels entered only on the wait-for-interrupt pulse
// - any reset lands in normal run, regulator at full power
// - normal wait: core clock off, peripherals clocked, interrupt wakes to run
// - normal stop: retention, detector on, peripheral clocks off, async unit wakes
// - very low power run: flash at 1 MHz, detector off, core and peripheral clocks 2 MHz
// - very low power wait: as very low power run with core and flash stopped
// - very low power stop: detector off, clocks off, low-power analog usable
// - low leakage stop: state kept, wakeup unit wakes, its interrupt resumes run
// - leakage stop level 3: both SRAM halves powered and retained
// - leakage stop level 2: lower half off, part of upper half kept
// - leakage stop level 1: all SRAM off, only the two register files kept
// - battery only: only battery domain alive, exit by full power-up sequence
// - leakage stop recovery runs reset flow with wakeup flag left set
// - pin states held in every stop and leakage mode
// - each run mode has its own wait and stop mode
module pms_mode_seq
  import pms_pkg::*;
#(
  parameter int WAKE_RST_CYC = `PMS_WAKE_RST_CYC,
  parameter int PWRUP_CYC    = `PMS_PWRUP_CYC
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // core requests
  input  wire logic              wfi_i,
  input  wire pms_pkg::pms_mode_e tgt_mode_i,
  input  wire logic              leakage_wakeup_unit_flag_clr_i,
  // wake sources and supply status, asynchronous
  input  wire logic              irq_pend_i,
  input  wire logic              leakage_wakeup_unit_wake_i,
  input  wire logic              main_pwr_ok_i,
  // mode status
  output pms_pkg::pms_mode_e     mode_o,
  output logic                   wake_rst_o,
  output logic                   pwrup_busy_o,
  output logic                   leakage_wakeup_unit_flag_o,
  // clock enables
  output logic                   core_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic                   core_interrupt_controller_clk_en_o,
  output logic                   flash_clk_en_o,
  output logic                   irc_sel_o,
  // wake logic enables
  output logic                   async_wake_unit_en_o,
  output logic                   leakage_wakeup_unit_en_o,
  output logic                   lp_periph_en_o,
  output logic                   adc_pin_irq_en_o,
  // supplies and retention
  output logic                   reg_full_o,
  output logic                   lvd_en_o,
  output logic                   core_pwr_o,
  output logic                   sram_l_pwr_o,
  output logic                   sram_u_pwr_o,
  output logic                   sram_u_part_o,
  output logic                   regfile_pwr_o,
  output logic                   io_hold_o
);
  import pms_pkg::*;

  // refuse sequence lengths the counter cannot hold
  if (WAKE_RST_CYC < 1 || PWRUP_CYC < 1 ||
      WAKE_RST_CYC > 255 || PWRUP_CYC > 255) begin : g_chk
    $error("pms_mode_seq: sequence length out of range");
  end

  localparam logic [`PMS_CNT_W-1:0] WAKE_LAST  = `PMS_CNT_W'(WAKE_RST_CYC - 1);
  localparam logic [`PMS_CNT_W-1:0] PWRUP_LAST = `PMS_CNT_W'(PWRUP_CYC - 1);

  // synchronisers for the asynchronous inputs
  logic [`PMS_SYNC_W-1:0] async_in;
  logic [`PMS_SYNC_W-1:0] sync1_r;
  logic [`PMS_SYNC_W-1:0] sync2_r;

  assign async_in[`PMS_SYNC_IRQ]     = irq_pend_i;
  assign async_in[`PMS_SYNC_LEAKAGE_WAKEUP_UNIT]    = leakage_wakeup_unit_wake_i;
  assign async_in[`PMS_SYNC_MAINPWR] = main_pwr_ok_i;

  for (genvar i = 0; i < `PMS_SYNC_W; i++) begin : g_sync
    // two stages per input bit
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        sync1_r[i] <= 1'b0;
        sync2_r[i] <= 1'b0;
      end else begin
        sync1_r[i] <= async_in[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end

  wire irq_s     = sync2_r[`PMS_SYNC_IRQ];
  wire leakage_wakeup_unit_s    = sync2_r[`PMS_SYNC_LEAKAGE_WAKEUP_UNIT];
  wire mainpwr_s = sync2_r[`PMS_SYNC_MAINPWR];

  // state
  pms_mode_e               mode_r;
  pms_mode_e               mode_nxt;
  pms_seq_e                seq_r;
  pms_seq_e                seq_nxt;
  logic [`PMS_CNT_W-1:0]   cnt_r;
  logic [`PMS_CNT_W-1:0]   cnt_nxt;
  logic                    leakage_wakeup_unit_flag_r;
  logic                    supply_seen_r;

  // reduced-rate enable pulses
  pms_div_if div_bus ();

  pms_clk_div u_div (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .div       (div_bus.provider)
  );

  // mode groups
  wire in_seq      = (seq_r != PMS_SEQ_IDLE);
  wire is_run      = (mode_r == PMS_RUN);
  wire is_very_low_power_run     = (mode_r == PMS_VLP_RUN);
  wire is_vlp_any  = (mode_r == PMS_VLP_RUN) || (mode_r == PMS_VLP_WAIT) ||
                     (mode_r == PMS_VLP_STOP);
  wire is_leak     = (mode_r == PMS_LEAK_STOP3) || (mode_r == PMS_LEAK_STOP2) ||
                     (mode_r == PMS_LEAK_STOP1);
  wire is_deep     = (mode_r == PMS_STOP) || (mode_r == PMS_VLP_STOP) ||
                     (mode_r == PMS_LL_STOP) || is_leak;

  // legal targets of a wait-for-interrupt from each run mode
  wire tgt_common  = (tgt_mode_i == PMS_LL_STOP) || (tgt_mode_i == PMS_LEAK_STOP3) ||
                     (tgt_mode_i == PMS_LEAK_STOP2) || (tgt_mode_i == PMS_LEAK_STOP1);
  wire tgt_ok_run  = (tgt_mode_i == PMS_WAIT) || (tgt_mode_i == PMS_STOP) ||
                     (tgt_mode_i == PMS_VLP_RUN) || tgt_common;
  wire tgt_ok_very_low_power_run = (tgt_mode_i == PMS_VLP_WAIT) || (tgt_mode_i == PMS_VLP_STOP) ||
                     (tgt_mode_i == PMS_RUN) || tgt_common;
  wire enter_ok    = !in_seq && wfi_i &&
                     ((is_run && tgt_ok_run) || (is_very_low_power_run && tgt_ok_very_low_power_run));
  wire seq_done    = (seq_r == PMS_SEQ_WAKE_RST) ? (cnt_r == WAKE_LAST) :
                                                   (cnt_r == PWRUP_LAST);

  // next mode and recovery sequence
  always_comb begin
    mode_nxt = mode_r;
    seq_nxt  = seq_r;
    cnt_nxt  = in_seq ? cnt_r + `PMS_CNT_W'(1) : '0;
    if (!mainpwr_s && supply_seen_r) begin
      mode_nxt = PMS_BATTERY_ONLY;
      seq_nxt  = PMS_SEQ_IDLE;
      cnt_nxt  = '0;
    end else if (in_seq) begin
      if (seq_done) begin
        mode_nxt = PMS_RUN;
        seq_nxt  = PMS_SEQ_IDLE;
        cnt_nxt  = '0;
      end
    end else begin
      case (mode_r)
        PMS_RUN,
        PMS_VLP_RUN: begin
          if (enter_ok) begin
            mode_nxt = tgt_mode_i;
          end
        end
        PMS_WAIT,
        PMS_STOP: begin
          if (irq_s) begin
            mode_nxt = PMS_RUN;
          end
        end
        PMS_VLP_WAIT,
        PMS_VLP_STOP: begin
          if (irq_s) begin
            mode_nxt = PMS_VLP_RUN;
          end
        end
        PMS_LL_STOP: begin
          if (leakage_wakeup_unit_s) begin
            mode_nxt = PMS_RUN;
          end
        end
        PMS_LEAK_STOP3,
        PMS_LEAK_STOP2,
        PMS_LEAK_STOP1: begin
          if (leakage_wakeup_unit_s) begin
            seq_nxt = PMS_SEQ_WAKE_RST;
            cnt_nxt = '0;
          end
        end
        PMS_BATTERY_ONLY: begin
          if (mainpwr_s) begin
            seq_nxt = PMS_SEQ_PWRUP;
            cnt_nxt = '0;
          end
        end
        default: begin
          mode_nxt = PMS_RUN;
        end
      endcase
    end
  end

  // wakeup unit flag: set by a wake out of low leakage or leakage stop, set wins
  wire leakage_wakeup_unit_set   = leakage_wakeup_unit_s && ((mode_r == PMS_LL_STOP) || is_leak) && !in_seq;
  wire leakage_wakeup_unit_f_nxt = leakage_wakeup_unit_set || (leakage_wakeup_unit_flag_r && !leakage_wakeup_unit_flag_clr_i);

  // mode, sequence and flag registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r        <= PMS_RUN;
      seq_r         <= PMS_SEQ_IDLE;
      cnt_r         <= '0;
      leakage_wakeup_unit_flag_r   <= 1'b0;
      supply_seen_r <= 1'b0;
    end else begin
      mode_r        <= mode_nxt;
      seq_r         <= seq_nxt;
      cnt_r         <= cnt_nxt;
      leakage_wakeup_unit_flag_r   <= leakage_wakeup_unit_f_nxt;
      supply_seen_r <= supply_seen_r || mainpwr_s;
    end
  end

  // divider runs in all three very low power modes, stop included
  assign div_bus.run = is_vlp_any && !in_seq;

  // per-mode decode of clocks, supplies and retention
  wire clocked   = !in_seq && (mode_r != PMS_BATTERY_ONLY);
  wire core_en   = clocked && (is_run || (is_very_low_power_run && div_bus.core_tick));
  wire per_en    = clocked && (is_run || (mode_r == PMS_WAIT) ||
                   (((mode_r == PMS_VLP_RUN) || (mode_r == PMS_VLP_WAIT)) &&
                    div_bus.core_tick));
  wire core_interrupt_controller_en   = clocked && (is_run || (mode_r == PMS_WAIT) ||
                   (((mode_r == PMS_VLP_RUN) || (mode_r == PMS_VLP_WAIT)) &&
                    div_bus.core_tick));
  wire flash_en  = clocked && (is_run || (is_very_low_power_run && div_bus.flash_tick));
  wire async_wake_unit_en   = (mode_r == PMS_STOP) || (mode_r == PMS_VLP_STOP);
  wire leakage_wakeup_unit_en   = ((mode_r == PMS_LL_STOP) || is_leak) && !in_seq;
  wire lp_per_en = (mode_r != PMS_BATTERY_ONLY) && !in_seq;
  wire adc_pin   = (mode_r != PMS_BATTERY_ONLY) && !is_leak &&
                   (mode_r != PMS_LL_STOP) && !in_seq;
  wire reg_full  = !is_vlp_any && (mode_r != PMS_BATTERY_ONLY);
  wire lvd_en    = (is_run || (mode_r == PMS_WAIT) || (mode_r == PMS_STOP)) &&
                   !in_seq;
  wire core_pwr  = !is_leak && (mode_r != PMS_BATTERY_ONLY);
  wire sram_l    = (mode_r != PMS_LEAK_STOP2) && (mode_r != PMS_LEAK_STOP1) &&
                   (mode_r != PMS_BATTERY_ONLY);
  wire sram_u    = (mode_r != PMS_LEAK_STOP2) && (mode_r != PMS_LEAK_STOP1) &&
                   (mode_r != PMS_BATTERY_ONLY);
  wire sram_part = sram_u || (mode_r == PMS_LEAK_STOP2);
  wire regfile   = (mode_r != PMS_BATTERY_ONLY);
  wire io_hold   = is_deep || (mode_r == PMS_BATTERY_ONLY) || in_seq;

  // output registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_o           <= PMS_RUN;
      wake_rst_o       <= 1'b0;
      pwrup_busy_o     <= 1'b0;
      leakage_wakeup_unit_flag_o      <= 1'b0;
      core_clk_en_o    <= 1'b1;
      periph_clk_en_o  <= 1'b1;
      core_interrupt_controller_clk_en_o    <= 1'b1;
      flash_clk_en_o   <= 1'b1;
      irc_sel_o        <= 1'b0;
      async_wake_unit_en_o        <= 1'b0;
      leakage_wakeup_unit_en_o        <= 1'b0;
      lp_periph_en_o   <= 1'b1;
      adc_pin_irq_en_o <= 1'b1;
      reg_full_o       <= 1'b1;
      lvd_en_o         <= 1'b1;
      core_pwr_o       <= 1'b1;
      sram_l_pwr_o     <= 1'b1;
      sram_u_pwr_o     <= 1'b1;
      sram_u_part_o    <= 1'b1;
      regfile_pwr_o    <= 1'b1;
      io_hold_o        <= 1'b0;
    end else begin
      mode_o           <= mode_r;
      wake_rst_o       <= (seq_r == PMS_SEQ_WAKE_RST);
      pwrup_busy_o     <= (seq_r == PMS_SEQ_PWRUP);
      leakage_wakeup_unit_flag_o      <= leakage_wakeup_unit_flag_r;
      core_clk_en_o    <= core_en;
      periph_clk_en_o  <= per_en;
      core_interrupt_controller_clk_en_o    <= core_interrupt_controller_en;
      flash_clk_en_o   <= flash_en;
      irc_sel_o        <= is_vlp_any;
      async_wake_unit_en_o        <= async_wake_unit_en;
      leakage_wakeup_unit_en_o        <= leakage_wakeup_unit_en;
      lp_periph_en_o   <= lp_per_en;
      adc_pin_irq_en_o <= adc_pin;
      reg_full_o       <= reg_full;
      lvd_en_o         <= lvd_en;
      core_pwr_o       <= core_pwr;
      sram_l_pwr_o     <= sram_l;
      sram_u_pwr_o     <= sram_u;
      sram_u_part_o    <= sram_part;
      regfile_pwr_o    <= regfile;
      io_hold_o        <= io_hold;
    end
  end
endmodule // pms_mode_seq
`default_nettype wire

// [inc/pms_consts.svh]
// timing counts, divider ratios and widths of the power mode sequencer
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH
`define PMS_CLK_HZ         20000000
`define PMS_CLK_NS         50
`define PMS_VLP_CORE_HZ    2000000
`define PMS_VLP_FLASH_HZ   1000000
`define PMS_DIV_CORE       (`PMS_CLK_HZ / `PMS_VLP_CORE_HZ)
`define PMS_DIV_FLASH      (`PMS_CLK_HZ / `PMS_VLP_FLASH_HZ)
`define PMS_WAKE_RST_NS    1000
`define PMS_WAKE_RST_CYC   ((`PMS_WAKE_RST_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)
`define PMS_PWRUP_NS       10000
`define PMS_PWRUP_CYC      ((`PMS_PWRUP_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)
`define PMS_CNT_W          8
`define PMS_SYNC_W         3
`define PMS_SYNC_IRQ       0
`define PMS_SYNC_LEAKAGE_WAKEUP_UNIT      1
`define PMS_SYNC_MAINPWR   2
`endif

// [inc/pms_div_if.sv]
// carrier between the sequencer and its clock-enable divider
`timescale 1ns/100ps
`default_nettype none
interface pms_div_if;
  logic run;       // divider counts while high
  logic core_tick; // 2 MHz enable pulse
  logic flash_tick; // 1 MHz enable pulse
  modport provider (input run, output core_tick, output flash_tick);
  modport user     (output run, input core_tick, input flash_tick);
endinterface : pms_div_if
`default_nettype wire

// [inc/pms_pkg.sv]
// types of the power mode sequencer
package pms_pkg;
  // normal run plus ten reduced-power modes
  typedef enum logic [3:0] {
    PMS_RUN,
    PMS_WAIT,
    PMS_STOP,
    PMS_VLP_RUN,
    PMS_VLP_WAIT,
    PMS_VLP_STOP,
    PMS_LL_STOP,
    PMS_LEAK_STOP3,
    PMS_LEAK_STOP2,
    PMS_LEAK_STOP1,
    PMS_BATTERY_ONLY
  } pms_mode_e;

  // recovery sequence running beside the mode
  typedef enum logic [1:0] {
    PMS_SEQ_IDLE,
    PMS_SEQ_WAKE_RST,
    PMS_SEQ_PWRUP
  } pms_seq_e;
endpackage : pms_pkg

// [verification/pms_far_model.sv]
// model of the core, wake sources and main supply
`timescale 1ns/100ps
`default_nettype none
module pms_far_model
  import pms_pkg::*;
(
  // clock
  input  wire logic          clk_sys_i,
  // requests, wake levels and supply
  output pms_pkg::pms_mode_e tgt_mode_i,
  output logic               wfi_i,
  output logic               leakage_wakeup_unit_flag_clr_i,
  output logic               irq_pend_i,
  output logic               leakage_wakeup_unit_wake_i,
  output logic               main_pwr_ok_i
);
  // idle levels at time zero
  initial begin
    tgt_mode_i = PMS_BATTERY_ONLY;
    wfi_i = 1'b0;
    leakage_wakeup_unit_flag_clr_i = 1'b0;
    irq_pend_i = 1'b0;
    leakage_wakeup_unit_wake_i = 1'b0;
    main_pwr_ok_i = 1'b1;
  end
  // one-cycle wait-for-interrupt pulse with its target
  task automatic wait_for_interrupt_instr(input pms_mode_e m);
    @(negedge clk_sys_i);
    wfi_i = 1'b1;
    tgt_mode_i = m;
    @(negedge clk_sys_i);
    wfi_i = 1'b0;
    tgt_mode_i = PMS_BATTERY_ONLY; // unqualified target shows an illegal code
  endtask
  // wake levels stay until changed
  task automatic wake(input logic irq, input logic leakage_wakeup_unit);
    @(negedge clk_sys_i);
    irq_pend_i = irq;
    leakage_wakeup_unit_wake_i = leakage_wakeup_unit;
  endtask
  // main supply level
  task automatic supply(input logic ok);
    @(negedge clk_sys_i);
    main_pwr_ok_i = ok;
  endtask
  // wakeup interrupt is left unmasked and serviced by clearing its flag
  task automatic service;
    @(negedge clk_sys_i);
    leakage_wakeup_unit_flag_clr_i = 1'b1;
    @(negedge clk_sys_i);
    leakage_wakeup_unit_flag_clr_i = 1'b0;
  endtask
endmodule // pms_far_model
`default_nettype wire

// [verification/pms_seq_monitor.sv]
// concurrent checks of the power mode sequencer at its ports
`timescale 1ns/100ps
`default_nettype none
module pms_seq_monitor
  import pms_pkg::*;
(
  // clock, reset and requests
  input wire logic               clk_sys_i,
  input wire logic               rst_i,
  input wire logic               wfi_i,
  input wire pms_pkg::pms_mode_e tgt_mode_i,
  input wire logic               irq_pend_i,
  input wire logic               leakage_wakeup_unit_wake_i,
  input wire logic               main_pwr_ok_i,
  // status
  input wire pms_pkg::pms_mode_e mode_o,
  input wire logic               wake_rst_o,
  input wire logic               pwrup_busy_o,
  input wire logic               leakage_wakeup_unit_flag_o,
  // enables and supplies
  input wire logic               core_clk_en_o,
  input wire logic               periph_clk_en_o,
  input wire logic               core_interrupt_controller_clk_en_o,
  input wire logic               flash_clk_en_o,
  input wire logic               irc_sel_o,
  input wire logic               async_wake_unit_en_o,
  input wire logic               leakage_wakeup_unit_en_o,
  input wire logic               lp_periph_en_o,
  input wire logic               adc_pin_irq_en_o,
  input wire logic               reg_full_o,
  input wire logic               lvd_en_o,
  input wire logic               core_pwr_o,
  input wire logic               sram_l_pwr_o,
  input wire logic               sram_u_pwr_o,
  input wire logic               sram_u_part_o,
  input wire logic               regfile_pwr_o,
  input wire logic               io_hold_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // request taken in run, and wake levels held through the synchroniser
  sequence s_wait_req;
    wfi_i && tgt_mode_i == PMS_WAIT ##1 mode_o == PMS_RUN && !wake_rst_o && !pwrup_busy_o;
  endsequence
  sequence s_irq_held;
    $rose(irq_pend_i) && mode_o == PMS_WAIT ##1 irq_pend_i [*3];
  endsequence
  sequence s_leakage_wakeup_unit_held;
    $rose(leakage_wakeup_unit_wake_i) && mode_o == PMS_LEAK_STOP2 ##1 leakage_wakeup_unit_wake_i [*3];
  endsequence
  // mode checks
  a_reset_run_mode: assert property (disable iff (1'b0) rst_i |-> mode_o == PMS_RUN && reg_full_o)
    else $error("reset does not give full power run");
  a_wait_entry: assert property (s_wait_req |=> mode_o == PMS_WAIT)
    else $error("wait request not entered");
  a_wait_gating: assert property (mode_o == PMS_WAIT |-> !core_clk_en_o && periph_clk_en_o && core_interrupt_controller_clk_en_o)
    else $error("wait clock gating wrong");
  a_wait_wake: assert property (s_irq_held |=> mode_o == PMS_RUN)
    else $error("interrupt did not end wait");
  a_wait_held: assert property ((main_pwr_ok_i && !irq_pend_i) [*4] ##0 mode_o == PMS_WAIT |=> mode_o == PMS_WAIT)
    else $error("wait left without cause");
  a_stop_gating: assert property (mode_o == PMS_STOP |-> lvd_en_o && !periph_clk_en_o && async_wake_unit_en_o && io_hold_o)
    else $error("stop state wrong");
  a_vlp_run_rate: assert property (mode_o == PMS_VLP_RUN |-> irc_sel_o && !lvd_en_o && !reg_full_o)
    else $error("reduced run state wrong");
  a_flash_pulse: assert property (mode_o == PMS_VLP_RUN && flash_clk_en_o ##1 mode_o == PMS_VLP_RUN |-> !flash_clk_en_o)
    else $error("flash enable not a pulse");
  a_vlp_wait_core: assert property (mode_o == PMS_VLP_WAIT |-> !core_clk_en_o && irc_sel_o && !lvd_en_o)
    else $error("reduced wait state wrong");
  a_vlp_stop_state: assert property (mode_o == PMS_VLP_STOP |-> !lvd_en_o && !core_interrupt_controller_clk_en_o && async_wake_unit_en_o
                                     && lp_periph_en_o && adc_pin_irq_en_o && io_hold_o && sram_l_pwr_o)
    else $error("reduced stop state wrong");
  a_lls_state: assert property (mode_o == PMS_LL_STOP |-> leakage_wakeup_unit_en_o && !core_interrupt_controller_clk_en_o && io_hold_o && sram_u_pwr_o)
    else $error("low leakage stop state wrong");
  a_leak3_sram: assert property (mode_o == PMS_LEAK_STOP3 |-> sram_l_pwr_o && sram_u_pwr_o && !core_pwr_o)
    else $error("level 3 memory power wrong");
  a_leak2_sram: assert property (mode_o == PMS_LEAK_STOP2 |-> !sram_l_pwr_o && !sram_u_pwr_o && sram_u_part_o)
    else $error("level 2 memory power wrong");
  a_leak1_sram: assert property (mode_o == PMS_LEAK_STOP1 |-> !sram_l_pwr_o && !sram_u_part_o && regfile_pwr_o)
    else $error("level 1 memory power wrong");
  a_battery_off: assert property (mode_o == PMS_BATTERY_ONLY |-> !core_pwr_o && !regfile_pwr_o && io_hold_o)
    else $error("battery only power wrong");
  a_leak_recover: assert property (s_leakage_wakeup_unit_held |=> wake_rst_o && leakage_wakeup_unit_flag_o)
    else $error("leakage recovery not started");
  a_flag_kept: assert property ($fell(wake_rst_o) |-> ##[0:1] mode_o == PMS_RUN && leakage_wakeup_unit_flag_o)
    else $error("recovery end wrong");
endmodule // pms_seq_monitor
bind pms_mode_seq pms_seq_monitor u_mon (.*);
`default_nettype wire

// [verification/power_mode_sequencer_bench.sv]
// self-checking bench of the power mode sequencer
`timescale 1ns/100ps
`default_nettype none
module power_mode_sequencer_bench;
  import pms_pkg::*;
  localparam int WR = 4; // short recovery reset flow
  localparam int PU = 8; // short power-up sequence
  logic      clk_sys_i;
  logic      rst_i;
  logic      wfi_i, leakage_wakeup_unit_flag_clr_i, irq_pend_i, leakage_wakeup_unit_wake_i, main_pwr_ok_i;
  pms_mode_e tgt_mode_i;
  pms_mode_e mode_o;
  logic      wake_rst_o, pwrup_busy_o, leakage_wakeup_unit_flag_o, core_clk_en_o, periph_clk_en_o, core_interrupt_controller_clk_en_o;
  logic      flash_clk_en_o, irc_sel_o, async_wake_unit_en_o, leakage_wakeup_unit_en_o, lp_periph_en_o, adc_pin_irq_en_o;
  logic      reg_full_o, lvd_en_o, core_pwr_o, sram_l_pwr_o, sram_u_pwr_o, sram_u_part_o;
  logic      regfile_pwr_o, io_hold_o;
  int        failures = 0;
  int        comparisons = 0;
  int        cyc = 0;
  // grouped views for compact comparison
  wire logic [3:0] clk_w = {core_clk_en_o, periph_clk_en_o, core_interrupt_controller_clk_en_o, irc_sel_o};
  wire logic [3:0] wk_w  = {lvd_en_o, async_wake_unit_en_o, leakage_wakeup_unit_en_o, io_hold_o};
  wire logic [3:0] ram_w = {sram_l_pwr_o, sram_u_pwr_o, sram_u_part_o, regfile_pwr_o};
  pms_mode_seq #(.WAKE_RST_CYC(WR), .PWRUP_CYC(PU)) DUT (.*);
  pms_far_model u_far (.*);
  // clock and hang limit
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic enter(input pms_mode_e m);
    u_far.wait_for_interrupt_instr(m);
    repeat (2) @(negedge clk_sys_i);
    chk("mode", m, mode_o);
  endtask
  task automatic await_mode(input pms_mode_e m);
    for (int i = 0; i < 40 && mode_o !== m; i++) @(negedge clk_sys_i);
    chk("mode", m, mode_o);
  endtask
  // normal run, wait and stop
  task automatic t_run_wait_stop;
    chk("run clocks", 4'he, clk_w);
    chk("run wake", 4'h9, {wk_w[3:1], reg_full_o});
    enter(PMS_WAIT);
    chk("wait clocks", 4'h6, clk_w);
    u_far.wait_for_interrupt_instr(PMS_STOP);
    repeat (3) @(negedge clk_sys_i);
    chk("mode", PMS_WAIT, mode_o);
    u_far.wake(1'b1, 1'b0);
    await_mode(PMS_RUN);
    u_far.wake(1'b0, 1'b0);
    enter(PMS_STOP);
    chk("stop clocks", 4'h0, clk_w);
    chk("stop wake", 4'hd, wk_w);
    chk("stop sram", 4'hf, ram_w);
    u_far.wake(1'b0, 1'b1);
    repeat (8) @(negedge clk_sys_i);
    chk("mode", PMS_STOP, mode_o);
    u_far.wake(1'b1, 1'b0);
    await_mode(PMS_RUN);
    u_far.wake(1'b0, 1'b0);
    $display("test run wait stop done");
  endtask
  // reduced power run, wait and stop
  task automatic t_vlp;
    int n_core;
    int n_fl;
    n_core = 0;
    n_fl = 0;
    enter(PMS_VLP_RUN);
    chk("vlp run", 4'h8, {irc_sel_o, lvd_en_o, reg_full_o, 1'b0});
    repeat (40) begin
      @(negedge clk_sys_i);
      if (core_clk_en_o === 1'b1) n_core++;
      if (flash_clk_en_o === 1'b1) n_fl++;
    end
    chk("core pulses", 4'h4, n_core[3:0]);
    chk("flash pulses", 4'h2, n_fl[3:0]);
    enter(PMS_VLP_WAIT);
    chk("vlp wait", 4'h8, {irc_sel_o, core_clk_en_o, lvd_en_o, 1'b0});
    u_far.wake(1'b1, 1'b0);
    await_mode(PMS_VLP_RUN);
    u_far.wake(1'b0, 1'b0);
    enter(PMS_VLP_STOP);
    chk("vlp stop wake", 4'h5, wk_w);
    chk("vlp stop use", 4'hc, {lp_periph_en_o, adc_pin_irq_en_o, periph_clk_en_o, core_interrupt_controller_clk_en_o});
    u_far.wake(1'b1, 1'b0);
    await_mode(PMS_VLP_RUN);
    u_far.wake(1'b0, 1'b0);
    enter(PMS_RUN);
    $display("test reduced power done");
  endtask
  // low leakage stop and the three leakage levels
  task automatic t_leak;
    pms_mode_e  lk[3] = '{PMS_LEAK_STOP3, PMS_LEAK_STOP2, PMS_LEAK_STOP1};
    logic [3:0] rm[3] = '{4'hf, 4'h3, 4'h1};
    int         n;
    enter(PMS_LL_STOP);
    chk("lls wake", 4'h3, wk_w);
    chk("lls sram", 4'hf, ram_w);
    u_far.wake(1'b1, 1'b0);
    repeat (8) @(negedge clk_sys_i);
    chk("mode", PMS_LL_STOP, mode_o);
    u_far.wake(1'b0, 1'b1);
    await_mode(PMS_RUN);
    chk("flag", 4'h1, leakage_wakeup_unit_flag_o);
    u_far.wake(1'b0, 1'b0);
    u_far.service;
    repeat (2) @(negedge clk_sys_i);
    chk("flag", 4'h0, leakage_wakeup_unit_flag_o);
    for (int k = 0; k < 3; k++) begin
      enter(lk[k]);
      chk("sram", rm[k], ram_w);
      u_far.wake(1'b0, 1'b1);
      n = 0;
      for (int i = 0; i < 20 && wake_rst_o !== 1'b1; i++) @(negedge clk_sys_i);
      while (wake_rst_o === 1'b1 && n < 99) begin
        n++;
        @(negedge clk_sys_i);
      end
      chk("reset flow length", 4'(WR), n[3:0]);
      await_mode(PMS_RUN);
      chk("flag", 4'h1, leakage_wakeup_unit_flag_o);
      u_far.wake(1'b0, 1'b0);
      u_far.service;
    end
    $display("test leakage stops done");
  endtask
  // loss of main supply and power-up
  task automatic t_battery;
    int n;
    n = 0;
    u_far.supply(1'b0);
    await_mode(PMS_BATTERY_ONLY);
    chk("bat sram", 4'h0, ram_w);
    chk("bat power", 4'h1, {core_pwr_o, reg_full_o, lp_periph_en_o, io_hold_o});
    u_far.supply(1'b1);
    for (int i = 0; i < 20 && pwrup_busy_o !== 1'b1; i++) @(negedge clk_sys_i);
    while (pwrup_busy_o === 1'b1 && n < 99) begin
      n++;
      @(negedge clk_sys_i);
    end
    chk("power-up length", 4'(PU), n[3:0]);
    await_mode(PMS_RUN);
    $display("test battery only done");
  endtask
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // reset then the scenarios
  initial begin
    rst_i = 1'b1;
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    t_run_wait_stop;
    t_vlp;
    t_leak;
    t_battery;
    conclude();
  end
endmodule // power_mode_sequencer_bench
`default_nettype wire
